// ===== shared/pll_cfg_pkg.sv
// Constants and types of the serial configuration register bank
package pll_cfg_pkg;
	localparam int ADDR_W   = 3;
	localparam int DATA_W   = 11;
	localparam int NUM_LOC  = 7;
	localparam int FRAME_W  = 15;
	localparam int CNT_W    = 4;
	localparam int FB_W     = 12;
	localparam int REF_W    = 10;
	localparam int SYNC_W   = 8;
	localparam int LOAD_W   = 3;
	localparam int SCALE_W  = 3;
	localparam int DIV4_W   = 2;

	localparam logic [CNT_W-1:0] LAST_BIT   = 4'hF;
	localparam logic [CNT_W-1:0] DATA_FIRST = 4'h4;

	// Locations
	localparam logic [ADDR_W-1:0] LOC_FB_DIV  = 3'h0;
	localparam logic [ADDR_W-1:0] LOC_LO_SYNC = 3'h1;
	localparam logic [ADDR_W-1:0] LOC_HI_SYNC = 3'h2;
	localparam logic [ADDR_W-1:0] LOC_REF     = 3'h3;
	localparam logic [ADDR_W-1:0] LOC_LOOP    = 3'h4;
	localparam logic [ADDR_W-1:0] LOC_FB_PH   = 3'h5;
	localparam logic [ADDR_W-1:0] LOC_OUT     = 3'h6;

	// Reset image, location 6 down to location 0
	localparam logic [NUM_LOC-1:0][DATA_W-1:0] RESET_IMAGE = {
		11'h047, 11'h5C1, 11'h5DC, 11'h013, 11'h006, 11'h003, 11'h04F
	};

	// Field positions
	localparam int B_REF_INV   = 10;
	localparam int B_OSC_GAIN  = 0;
	localparam int B_PD_GAIN   = 3;
	localparam int B_PD_EN     = 6;
	localparam int B_INTERNAL_FILTER_SELECT   = 7;
	localparam int B_INT_OSC   = 8;
	localparam int B_CLK_SEL   = 9;
	localparam int B_FB_INT    = 0;
	localparam int B_FB_INV    = 1;
	localparam int B_ADD       = 2;
	localparam int B_REMOVE    = 3;
	localparam int B_OUT_PS    = 4;
	localparam int B_FB_PS     = 6;
	localparam int B_FINE_DIR  = 8;
	localparam int B_FINE_EN   = 9;
	localparam int B_LOAD_CNT  = 0;
	localparam int B_OMUX      = 3;
	localparam int B_HOLD      = 7;
	localparam int B_TEST_EN   = 8;
	localparam int B_TEST_LVL  = 9;
	localparam int B_EXT_REF   = 10;

	typedef struct packed {
		logic sclk;
		logic serialSelectN;
		logic serialDataLine;
	} ser_pins_t;

	typedef struct packed {
		logic [2:0] oscillatorGainCode;
		logic [2:0] phaseDetectorGainCode;
		logic       internalFilterSelect;
		logic       internalOscillatorSelect;
		logic       fineEnable;
		logic       fineDirection;
		logic       externalReferenceBuffer;
	} analog_cfg_t;

	typedef enum logic [1:0] {ADJ_NONE, ADJ_ADD, ADJ_REMOVE} adjust_t;
	typedef enum {SER_IDLE, SER_SHIFT, SER_DRAIN} ser_state_t;
endpackage

// ===== design/mod_counter.sv
// Modulus counter with tick enable and programmable limit
`timescale 1ns/1ps
module mod_counter #(
	parameter int W = 12
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Count control
	input  wire logic         tick,
	input  wire logic [W-1:0] limit,
	// Count state
	output logic      [W-1:0] count,
	output logic              wrap
);
	logic [W-1:0] count_q;

	assign wrap  = tick && (count_q >= limit);
	assign count = count_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			count_q <= '0;
		else if (wrap)
			count_q <= '0;
		else if (tick)
			count_q <= count_q + W'(1);
	end
endmodule

// ===== design/pll_serial_config_register_bank.sv
// Serially loaded configuration bank with divider and output control logic
`timescale 1ns/1ps
// Contract
// - Every frame bit shifts least significant first
// - Flag, three location bits, eleven data bits
// - Location 0 feedback divide by value+1
// - Location 3 reference divide by value+1
// - Location 1 low sync count state
// - Location 2 high sync count state
// - Location 3 bit 10 inverts reference
// - Phase compare enable gates detector pulses
// - Internal filter and oscillator select bits
// - Bit 9 picks feedback divider clock
// - Feedback source select and external inversion
// - Bit 2 rise adds one cycle
// - Bit 3 rise removes one cycle
// - Removal lengthens one divider pass only
// - Output and feedback post-scaler fields
// - Fine phase enable and lead/lag
// - Auxiliary output source multiplexers
// - Load counter; hold forces clock outputs
// - Test mode drives clock outputs level
// - Reference buffer selects crystal or logic
// - Read is two frames, second drives data
// - Sixteen edges, last with select high
// - Hold release resumes on aux one rise
module pll_serial_config_register_bank (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// Serial programming pins
	input  wire pll_cfg_pkg::ser_pins_t  serialPins,
	output logic                         serialDataOut,
	output logic                         serialDataOe,
	// Reference and external feedback pins
	input  wire logic                    referencePin,
	input  wire logic                    externalFeedbackPin,
	// Analog loop controls
	output pll_cfg_pkg::analog_cfg_t     analogCfg,
	output logic                         phaseRefPulse,
	output logic                         phaseFbPulse,
	// Clock and auxiliary outputs
	output logic                         clkPos,
	output logic                         clkNeg,
	output logic [3:0]                   auxOut
);
	import pll_cfg_pkg::*;

	function automatic logic [SCALE_W-1:0] scaleMask(input logic [1:0] c);
		scaleMask = SCALE_W'(({SCALE_W{1'b1}} << c) ^ {SCALE_W{1'b1}});
	endfunction

	// Pin synchronisers
	logic [2:0] pinS1_q;
	logic [2:0] pinS2_q;
	logic [1:0] lnkS1_q;
	logic [1:0] lnkS2_q;
	logic       sclkPrev_q;
	logic       refPrev_q;
	logic       extPrev_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinS1_q <= 3'h2;
			pinS2_q <= 3'h2;
			lnkS1_q <= 2'h0;
			lnkS2_q <= 2'h0;
		end else begin
			pinS1_q <= serialPins;
			pinS2_q <= pinS1_q;
			lnkS1_q <= {referencePin, externalFeedbackPin};
			lnkS2_q <= lnkS1_q;
		end
	end

	wire sclkS     = pinS2_q[2];
	wire selNS     = pinS2_q[1];
	wire dataS     = pinS2_q[0];
	wire sclkRise  = sclkS && !sclkPrev_q;

	// Serial frame engine
	ser_state_t               state_q;
	ser_state_t               state_d;
	logic [CNT_W-1:0]         bitCnt_q;
	logic [CNT_W-1:0]         bitCnt_d;
	logic [FRAME_W-1:0]       shift_q;
	logic                     readPending_q;
	logic [ADDR_W-1:0]        readAddr_q;
	logic [NUM_LOC-1:0][DATA_W-1:0] mem_q;

	wire                frameFull  = bitCnt_q == CNT_W'(FRAME_W);
	wire                loadEdge   = sclkRise && selNS && frameFull;
	wire                loadStrobe = (state_q == SER_SHIFT) && loadEdge;
	wire                loadRead   = shift_q[0];
	wire [ADDR_W-1:0]   loadAddr   = shift_q[ADDR_W:1];
	wire [DATA_W-1:0]   loadData   = shift_q[FRAME_W-1:ADDR_W+1];
	wire                writeHit   = loadStrobe && !loadRead &&
		(loadAddr < ADDR_W'(NUM_LOC));
	wire                readHit    = loadStrobe && loadRead;
	wire [DATA_W-1:0]   readData   = (readAddr_q < ADDR_W'(NUM_LOC)) ?
		mem_q[readAddr_q] : '0;
	wire [CNT_W-1:0]    outPos     = bitCnt_d - DATA_FIRST;
	wire                outBit     = (bitCnt_d >= DATA_FIRST) &&
		(outPos < CNT_W'(DATA_W)) && readData[outPos];

	always_comb begin
		state_d  = state_q;
		bitCnt_d = bitCnt_q;
		case (state_q)
			SER_IDLE: begin
				bitCnt_d = '0;
				if (!selNS)
					state_d = readPending_q ? SER_DRAIN : SER_SHIFT;
			end
			SER_SHIFT, SER_DRAIN: begin
				if (sclkRise) begin
					if (selNS || frameFull)
						state_d = SER_IDLE;
					else
						bitCnt_d = bitCnt_q + CNT_W'(1);
				end
			end
			default: state_d = SER_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q    <= SER_IDLE;
			bitCnt_q   <= '0;
			shift_q    <= '0;
			sclkPrev_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			bitCnt_q   <= bitCnt_d;
			sclkPrev_q <= sclkS;
			if (state_q == SER_SHIFT && sclkRise && !selNS && !frameFull)
				shift_q <= {dataS, shift_q[FRAME_W-1:1]};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			readPending_q <= 1'b0;
			readAddr_q    <= '0;
			serialDataOut <= 1'b0;
			serialDataOe  <= 1'b0;
		end else begin
			if (readHit) begin
				readPending_q <= 1'b1;
				readAddr_q    <= loadAddr;
			end else if (state_q == SER_DRAIN && state_d == SER_IDLE)
				readPending_q <= 1'b0;
			serialDataOe  <= state_d == SER_DRAIN && !selNS;
			serialDataOut <= (state_d == SER_DRAIN) && outBit;
		end
	end

	// Configuration store, updated only on the load edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			mem_q <= RESET_IMAGE;
		else if (writeHit)
			mem_q[loadAddr] <= loadData;
	end

	// Field decode
	wire [DATA_W-1:0] fbValue   = mem_q[LOC_FB_DIV];
	wire [SYNC_W-1:0] loSync    = mem_q[LOC_LO_SYNC][SYNC_W-1:0];
	wire [SYNC_W-1:0] hiSync    = mem_q[LOC_HI_SYNC][SYNC_W-1:0];
	wire [REF_W-1:0]  refValue  = mem_q[LOC_REF][REF_W-1:0];
	wire              refInv    = mem_q[LOC_REF][B_REF_INV];
	wire              pdEnable  = mem_q[LOC_LOOP][B_PD_EN];
	wire              clkSel    = mem_q[LOC_LOOP][B_CLK_SEL];
	wire              fbInt     = mem_q[LOC_FB_PH][B_FB_INT];
	wire              fbInv     = mem_q[LOC_FB_PH][B_FB_INV];
	wire [1:0]        outPost   = mem_q[LOC_FB_PH][B_OUT_PS +: 2];
	wire [1:0]        fbPost    = mem_q[LOC_FB_PH][B_FB_PS +: 2];
	wire [LOAD_W-1:0] loadCnt   = mem_q[LOC_OUT][B_LOAD_CNT +: LOAD_W];
	wire [3:0]        omux      = mem_q[LOC_OUT][B_OMUX +: 4];
	wire              holdBit   = mem_q[LOC_OUT][B_HOLD];
	wire              testEn    = mem_q[LOC_OUT][B_TEST_EN];
	wire              testLevel = mem_q[LOC_OUT][B_TEST_LVL];

	always_comb begin
		analogCfg.oscillatorGainCode = mem_q[LOC_LOOP][B_OSC_GAIN +: 3];
		analogCfg.phaseDetectorGainCode = mem_q[LOC_LOOP][B_PD_GAIN +: 3];
		analogCfg.internalFilterSelect = mem_q[LOC_LOOP][B_INTERNAL_FILTER_SELECT];
		analogCfg.internalOscillatorSelect =
			mem_q[LOC_LOOP][B_INT_OSC];
		analogCfg.fineEnable = mem_q[LOC_FB_PH][B_FINE_EN];
		analogCfg.fineDirection = mem_q[LOC_FB_PH][B_FINE_DIR];
		analogCfg.externalReferenceBuffer =
			mem_q[LOC_OUT][B_EXT_REF];
	end

	// One-pass cycle add and remove requests
	wire addRise    = writeHit && loadAddr == LOC_FB_PH &&
		loadData[B_ADD] && !mem_q[LOC_FB_PH][B_ADD];
	wire removeRise = writeHit && loadAddr == LOC_FB_PH &&
		loadData[B_REMOVE] && !mem_q[LOC_FB_PH][B_REMOVE];
	adjust_t adjust_q;

	// Post-scalers and oscillator stand-in
	logic [SCALE_W-1:0] psCnt_q;
	logic [DIV4_W-1:0]  div4_q;
	wire outTick = (psCnt_q & scaleMask(outPost)) == '0;
	wire fbPsTick = (psCnt_q & scaleMask(fbPost)) == '0;
	wire fbTick = (clkSel ? outTick : 1'b1) && fbPsTick;

	// Feedback divider, one pass lengthened or shortened on request
	logic [FB_W-1:0] fbCount;
	logic            fbWrap;
	wire  [FB_W-1:0] fbBase  = FB_W'(fbValue);
	wire  [FB_W-1:0] fbLimit = (adjust_q == ADJ_REMOVE) ?
		fbBase + FB_W'(1) :
		(adjust_q == ADJ_ADD && fbBase != '0) ? fbBase - FB_W'(1) :
		fbBase;

	mod_counter #(.W(FB_W)) fbDivider (
		.clk   (clk),
		.rst   (rst),
		.tick  (fbTick),
		.limit (fbLimit),
		.count (fbCount),
		.wrap  (fbWrap)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			adjust_q <= ADJ_NONE;
		else if (removeRise)
			adjust_q <= ADJ_REMOVE;
		else if (addRise)
			adjust_q <= ADJ_ADD;
		else if (fbWrap && fbCount == fbLimit)
			adjust_q <= ADJ_NONE;
	end

	// Reference path with polarity and divider
	wire refLevel = lnkS2_q[1] ^ refInv;
	wire extLevel = lnkS2_q[0] ^ fbInv;
	wire refRise  = refLevel && !refPrev_q;
	wire extRise  = extLevel && !extPrev_q;
	logic [REF_W-1:0] refCount;
	logic             refWrap;

	mod_counter #(.W(REF_W)) refDivider (
		.clk   (clk),
		.rst   (rst),
		.tick  (refRise),
		.limit (refValue),
		.count (refCount),
		.wrap  (refWrap)
	);

	wire fbEvent  = fbInt ? fbWrap : extRise;
	wire loadHit  = fbCount == FB_W'(loadCnt);
	wire loHit    = fbCount == FB_W'(loSync);
	wire hiHit    = fbCount == FB_W'(hiSync);
	wire [3:0] div4 = {div4_q == 2'h3 || div4_q == 2'h0, div4_q[1],
		div4_q == 2'h1 || div4_q == 2'h2, !div4_q[1]};
	wire [3:0] auxD = {omux[3] ? div4[3] : hiHit, omux[2] ? div4[2] : loHit,
		omux[1] ? div4[1] : fbWrap, omux[0] ? div4[0] : loadHit};

	// Clock outputs with hold and test overrides
	logic holding_q;
	logic aux1Prev_q;
	wire  aux1Rise = auxOut[0] && !aux1Prev_q;
	wire  clkPosD  = testEn ? testLevel :
		holding_q ? 1'b1 :
		outTick ? !clkPos : clkPos;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refPrev_q     <= 1'b0;
			extPrev_q     <= 1'b0;
			psCnt_q       <= '0;
			div4_q        <= '0;
			auxOut        <= 4'h0;
			aux1Prev_q    <= 1'b0;
			phaseRefPulse <= 1'b0;
			phaseFbPulse  <= 1'b0;
		end else begin
			refPrev_q     <= refLevel;
			extPrev_q     <= extLevel;
			psCnt_q       <= psCnt_q + SCALE_W'(1);
			div4_q        <= div4_q + DIV4_W'(1);
			auxOut        <= auxD;
			aux1Prev_q    <= auxOut[0];
			phaseRefPulse <= pdEnable && refWrap;
			phaseFbPulse  <= pdEnable && fbEvent;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			holding_q <= 1'b0;
			clkPos    <= 1'b0;
			clkNeg    <= 1'b1;
		end else begin
			if (holdBit)
				holding_q <= 1'b1;
			else if (aux1Rise)
				holding_q <= 1'b0;
			clkPos <= clkPosD;
			clkNeg <= !clkPosD;
		end
	end

	// Checks
	sequence s_load;
		state_q == SER_SHIFT && sclkRise && selNS && frameFull;
	endsequence

	property p_store_stable;
		@(posedge clk) disable iff (rst)
		!loadStrobe |=> $stable(mem_q);
	endproperty
	a_store_stable: assert property (p_store_stable)
		else $error("store changed outside a load edge");

	property p_write_lands;
		@(posedge clk) disable iff (rst)
		s_load ##0 (!loadRead && loadAddr < ADDR_W'(NUM_LOC))
		|=> mem_q[$past(loadAddr)] == $past(loadData);
	endproperty
	a_write_lands: assert property (p_write_lands)
		else $error("written frame did not reach its location");

	property p_load_count;
		@(posedge clk) disable iff (rst)
		loadStrobe |-> bitCnt_q == CNT_W'(FRAME_W) && selNS;
	endproperty
	a_load_count: assert property (p_load_count)
		else $error("load taken before fifteen bits");

	property p_read_pending;
		@(posedge clk) disable iff (rst)
		readHit |=> readPending_q ##0 $stable(mem_q);
	endproperty
	a_read_pending: assert property (p_read_pending)
		else $error("read frame not armed");

	property p_remove_arm;
		@(posedge clk) disable iff (rst)
		removeRise |=> adjust_q == ADJ_REMOVE && fbLimit == fbBase + FB_W'(1);
	endproperty
	a_remove_arm: assert property (p_remove_arm)
		else $error("removal did not lengthen the pass");

	property p_one_pass;
		@(posedge clk) disable iff (rst)
		fbWrap && fbCount == fbLimit && !removeRise && !addRise
		|=> adjust_q == ADJ_NONE;
	endproperty
	a_one_pass: assert property (p_one_pass)
		else $error("adjustment outlived one pass");

	property p_pd_gate;
		@(posedge clk) disable iff (rst)
		!pdEnable |=> !phaseRefPulse && !phaseFbPulse;
	endproperty
	a_pd_gate: assert property (p_pd_gate)
		else $error("phase pulse while detector disabled");

	property p_test_level;
		@(posedge clk) disable iff (rst)
		testEn |=> clkPos == $past(testLevel) && clkNeg != clkPos;
	endproperty
	a_test_level: assert property (p_test_level)
		else $error("test level not on clock outputs");

	property p_hold_wait;
		@(posedge clk) disable iff (rst)
		holding_q && !testEn && !aux1Rise |=> holding_q && clkPos && !clkNeg;
	endproperty
	a_hold_wait: assert property (p_hold_wait)
		else $error("outputs left hold without aux one rise");
endmodule

// ===== verification/serial_host.sv
// Host model driving the three-wire serial programming link
`timescale 1ns/1ps
module serial_host (
	// Clock
	input  wire logic                  clk,
	// Serial link
	output pll_cfg_pkg::ser_pins_t     serialPins,
	input  wire logic                  serialDataOut,
	input  wire logic                  serialDataOe
);
	import pll_cfg_pkg::*;
	logic sclk    = 1'b0;
	logic serial_select_n    = 1'b1;
	logic hostBit = 1'b0;
	logic hostOe  = 1'b1;
	logic lastLvl;
	logic lineLvl;
	// Undriven line shows a changing pattern
	assign lineLvl = serialDataOe ? serialDataOut : hostOe ? hostBit : ~lastLvl;
	assign serialPins = {sclk, serial_select_n, lineLvl};
	always_ff @(posedge clk) lastLvl <= lineLvl;

	task automatic frame(input logic [14:0] word, input logic drive,
		input int n, output logic [14:0] seen);
		seen = '0;
		hostOe = drive;
		serial_select_n = 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			hostBit = word[i];
			repeat (4) @(negedge clk);
			seen[i] = lineLvl;
			sclk = 1'b1;
			repeat (4) @(negedge clk);
			sclk = 1'b0;
		end
		serial_select_n = 1'b1;
		hostOe = 1'b1;
		repeat (4) @(negedge clk);
		sclk = 1'b1;
		repeat (4) @(negedge clk);
		sclk = 1'b0;
		repeat (6) @(negedge clk);
	endtask

	task automatic write(input logic [2:0] a, input logic [10:0] d);
		logic [14:0] s;
		frame({d, a, 1'b0}, 1'b1, 15, s);
	endtask

	// Second frame released to the device
	task automatic read(input logic [2:0] a, output logic [14:0] s);
		frame({11'h000, a, 1'b1}, 1'b1, 15, s);
		frame(15'h0000, 1'b0, 15, s);
	endtask
endmodule

// ===== verification/tb_top.sv
// Testbench for the serial configuration register bank
`timescale 1ns/1ps
module tb_top;
	import pll_cfg_pkg::*;
	logic        clk    = 1'b0;
	logic        rst    = 1'b1;
	logic        refPin = 1'b0;
	logic        extFb  = 1'b0;
	ser_pins_t   pins;
	logic        sdo;
	logic        sdoe;
	analog_cfg_t acfg;
	logic        refP;
	logic        fbP;
	logic        clkPos;
	logic        clkNeg;
	logic [3:0]  auxOut;
	int          errCount = 0;
	int          checks   = 0;
	int          cyc      = 0;
	int          fbT[$];
	logic [14:0] s;
	logic [10:0] img [0:6] = '{11'h04F, 11'h003, 11'h006, 11'h013,
		11'h5DC, 11'h5C1, 11'h047};

	pll_serial_config_register_bank pll_serial_config_register_bank_inst (
		.clk                 (clk),
		.rst                 (rst),
		.serialPins          (pins),
		.serialDataOut       (sdo),
		.serialDataOe        (sdoe),
		.referencePin        (refPin),
		.externalFeedbackPin (extFb),
		.analogCfg           (acfg),
		.phaseRefPulse       (refP),
		.phaseFbPulse        (fbP),
		.clkPos              (clkPos),
		.clkNeg              (clkNeg),
		.auxOut              (auxOut)
	);

	serial_host serial_host_inst (
		.clk           (clk),
		.serialPins    (pins),
		.serialDataOut (sdo),
		.serialDataOe  (sdoe)
	);

	initial forever #12.5 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			errCount++;
			end_sim();
		end
	end

	always @(negedge clk) if (fbP === 1'b1) fbT.push_back(cyc);

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errCount++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rc(input logic [2:0] a, input logic [10:0] e);
		serial_host_inst.read(a, s);
		check({1'b0, s}, {1'b0, e, 4'h0});
	endtask

	task automatic wr(input logic [2:0] a, input logic [10:0] d);
		serial_host_inst.write(a, d);
	endtask

	task automatic t_reset();
		for (int a = 0; a < 7; a++)
			rc(3'(a), img[a]);
		check({3'h0, acfg}, {3'h0, 3'h4, 3'h3, 5'h1A});
		$display("reset test done");
	endtask

	task automatic t_regs();
		logic [10:0] p [0:6] = '{11'h2A5, 11'h1B3, 11'h64C, 11'h3F1,
			11'h42B, 11'h7F1, 11'h4B8};
		int ones;
		for (int a = 0; a < 7; a++) begin
			wr(3'(a), p[a]);
			rc(3'(a), p[a]);
		end
		check({3'h0, acfg}, {3'h0, 3'h3, 3'h5, 5'h07});
		check({14'h0, clkPos, clkNeg}, 16'h0002);
		wr(3'h7, 11'h7FF);
		rc(3'h7, 11'h000);
		// Frame cut short after eight bits
		serial_host_inst.frame(15'h0000, 1'b1, 8, s);
		rc(3'h0, 11'h2A5);
		wr(3'h6, 11'h300);
		check({14'h0, clkPos, clkNeg}, 16'h0002);
		wr(3'h6, 11'h100);
		check({14'h0, clkPos, clkNeg}, 16'h0001);
		wr(3'h6, 11'h078);
		ones = 0;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			ones += int'(auxOut[0]);
			check({14'h0, auxOut[0] ^ auxOut[2], auxOut[1] ^ auxOut[3]},
				16'h0003);
		end
		check(16'(ones), 16'h0002);
		$display("register test done");
	endtask

	task automatic t_phase();
		int n;
		wr(3'h3, 11'h003);
		for (int k = 0; k < 2; k++) begin
			wr(3'h4, (k == 1) ? 11'h59C : 11'h5DC);
			n = 0;
			for (int i = 0; i < 160; i++) begin
				@(negedge clk);
				if (i % 2 == 0) refPin = ~refPin;
				n += int'(refP === 1'b1);
			end
			check({15'h0, (k == 1) ? (n == 0) : (n >= 9 && n <= 11)},
				16'h0001);
		end
		wr(3'h4, 11'h5DC);
		$display("phase detector test done");
	endtask

	task automatic t_ext();
		int n;
		wr(3'h5, 11'h400);
		n = 0;
		for (int i = 0; i < 48; i++) begin
			@(negedge clk);
			if (i % 4 == 0 && i < 40) extFb = ~extFb;
			n += int'(fbP === 1'b1);
		end
		check(16'(n), 16'h0005);
		$display("external feedback test done");
	endtask

	task automatic adjust(input logic [10:0] v, input int odd);
		int nOdd;
		int nBad;
		int d;
		nOdd = 0;
		nBad = 0;
		fbT.delete();
		wr(3'h5, v);
		repeat (60) @(negedge clk);
		for (int i = 1; i < fbT.size(); i++) begin
			d = fbT[i] - fbT[i-1];
			if (d == odd) nOdd++;
			else if (d != 10) nBad++;
		end
		check(16'(nBad), 16'h0000);
		if (odd != 10) check(16'(nOdd), 16'h0001);
	endtask

	task automatic t_adjust();
		wr(3'h0, 11'h009);
		wr(3'h5, 11'h401);
		adjust(11'h401, 10);
		adjust(11'h409, 11);
		adjust(11'h401, 10);
		adjust(11'h405, 9);
		$display("cycle adjust test done");
	endtask

	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_reset();
		t_regs();
		t_phase();
		t_ext();
		t_adjust();
		end_sim();
	end
endmodule
